/* speh_serial_port.v */
`timescale 1ns/10ps
`include "speh_map.vh"
// Overview of operation
// R01: Overrun flag sets when data unread, buffer full and shifter full together.
// R02: Shifter moves to buffer only when buffer free; otherwise shifter overwritten.
// R03: Overrun cannot set before three elements received since receiver reset.
// R04: Host reads received data at least 2.5 bit clocks before third element ends.
// R05: Overrun clears on data read or receiver reset; restart needs new sync.
// R06: Receive sync is unexpected when it comes too early before last bit.
// R07: Receive sync ignore set: unexpected syncs ignored, reception continues.
// R08: First sync after reset or overrun clear, or in gap, is normal.
// R09: Unexpected receive sync sets error flag; software writes set or clear it.
// R10: Receive interrupt mode 11b routes receive sync error to interrupt.
// R11: Second write before copy replaces transmit data; old value never sent.
// R12: Transmit interrupt mode 00b routes ready flag; host writes after ready.
// R13: Empty asserts after shifter drained without reload, or after restart.
// R14: Underflow resends old data each sync; empty clears on fresh copy.
// R15: Copy-driven sync mode generates no sync until new data copied.
// R16: On transmit reset release ready=1, empty low; early sync sends zeros.
// R17: Controller pulses transmit reset after first enable; disable clears error.
// R18: Transmit sync is unexpected when it comes too early before last bit.
// R19: Transmit sync ignore set: unexpected syncs ignored, transmission continues.
// R20: First transmit sync after reset, or in gap, is normal.
// R21: Unexpected transmit sync sets error flag; software writes set or clear it.
// R22: Transmit interrupt mode 11b routes transmit sync error to interrupt.
// R23: Unignored unexpected receive sync aborts element and restarts reception.
// R24: Unignored unexpected transmit sync restarts the same element after delay.
module speh_serial_port #(
  parameter WORD_BITS = `SPEH_WORD_BITS
) (
  input wire i_clk,
  input wire i_reset,
  // Pins to and from the external device
  input wire i_rx_bit_clock,
  input wire i_rx_frame_sync,
  input wire i_serial_in,
  input wire i_tx_bit_clock,
  input wire i_tx_frame_sync,
  output wire o_serial_out,
  output wire o_tx_frame_sync,
  // Control bits
  input wire i_rx_reset_n,
  input wire i_tx_reset_n,
  input wire i_rx_sync_ignore,
  input wire i_tx_sync_ignore,
  input wire [1:0] i_rx_data_delay,
  input wire [1:0] i_tx_data_delay,
  input wire [1:0] i_rx_irq_mode,
  input wire [1:0] i_tx_irq_mode,
  input wire i_tx_sync_source_sel,
  input wire i_tx_sync_gen_mode,
  // Host data access
  input wire i_rx_data_rd,
  output wire [WORD_BITS-1:0] o_rx_data,
  input wire i_tx_data_wr,
  input wire [WORD_BITS-1:0] i_tx_data,
  // Software access to the sync error flags
  input wire i_rx_sync_err_wr,
  input wire i_rx_sync_err_wdata,
  input wire i_tx_sync_err_wr,
  input wire i_tx_sync_err_wdata,
  // Status
  output wire o_rx_ready_flag,
  output wire o_rx_overrun_flag,
  output wire o_rx_sync_error_flag,
  output wire o_tx_ready_flag,
  output wire o_tx_empty_n,
  output wire o_tx_sync_error_flag,
  output wire o_rx_irq,
  output wire o_tx_irq,
  output wire o_tx_dma_event
);
  localparam CW = `SPEH_CNT_W;
  localparam [31:0] LAST_BIT_W = WORD_BITS - 1;
  localparam [CW-1:0] LAST_BIT = LAST_BIT_W[CW-1:0];
  // Frame phase states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;

  wire [4:0] pins_s;
  reg rclk_d_reg;
  reg tclk_d_reg;
  speh_sync2 #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_rx_bit_clock, i_rx_frame_sync, i_serial_in, i_tx_bit_clock, i_tx_frame_sync}),
    .o_sync(pins_s)
  );
  wire rclk_s = pins_s[4];
  wire rfs_s = pins_s[3];
  wire din_s = pins_s[2];
  wire tclk_s = pins_s[1];
  wire tfs_s = pins_s[0];
  // Receive samples on falling edge, transmit drives on rising edge
  wire rx_edge = rclk_d_reg & ~rclk_s;
  wire tx_edge = ~tclk_d_reg & tclk_s;
  always @(posedge i_clk) begin
    if (i_reset) begin
      rclk_d_reg <= 1'b0;
      tclk_d_reg <= 1'b0;
    end else begin
      rclk_d_reg <= rclk_s;
      tclk_d_reg <= tclk_s;
    end
  end

  // ---------------- Receiver ----------------
  reg [1:0] rst_reg;
  reg [CW-1:0] rcnt_reg;
  reg [WORD_BITS-1:0] rsr_reg;
  reg [WORD_BITS-1:0] rbr_reg;
  reg [WORD_BITS-1:0] drr_reg;
  reg rsr_full_reg;
  reg rbr_full_reg;
  reg rx_ready_flag_reg;
  reg rx_overrun_flag_reg;
  reg rwait_reg;
  reg [1:0] relem_reg;
  reg rx_sync_error_flag_reg;
  wire rx_run = ~i_reset & i_rx_reset_n;
  // Early sync: sync lands while data bits remain beyond the delay window
  wire [CW-1:0] r_left = LAST_BIT - rcnt_reg;
  wire r_early = (rst_reg == ST_DATA) && (r_left >= {{(CW-2){1'b0}}, i_rx_data_delay}); // [R06]
  wire r_sync = rx_edge & rfs_s;
  wire r_unexp = r_sync & r_early & ~rwait_reg; // [R08]
  wire r_accept = r_sync & ~(r_early & ~rwait_reg);
  wire r_done = rx_edge & (rst_reg == ST_DATA) & (rcnt_reg == LAST_BIT) & ~r_unexp;
  wire r_copy_ok = ~rbr_full_reg;
  // Buffer to data copy allowed once host has read the previous word
  wire rb2d = rbr_full_reg & ~rx_ready_flag_reg;
  // Receive framing and shifting
  always @(posedge i_clk) begin
    if (~rx_run) begin
      rst_reg <= ST_IDLE;
      rcnt_reg <= {CW{1'b0}};
      rsr_reg <= {WORD_BITS{1'b0}};
      rsr_full_reg <= 1'b0;
      rwait_reg <= 1'b1;
      relem_reg <= 2'h0;
    end else begin
      if (rx_overrun_flag_reg && i_rx_data_rd) begin
        rwait_reg <= 1'b1; // [R05]
      end
      if (r_unexp && !i_rx_sync_ignore) begin
        // Abort element, discard shifter content
        rst_reg <= (i_rx_data_delay == 2'h0) ? ST_DATA : ST_DELAY; // [R23]
        rcnt_reg <= {CW{1'b0}};
        rsr_full_reg <= 1'b0;
      end else if (r_accept && !(r_early && i_rx_sync_ignore)) begin
        rst_reg <= (i_rx_data_delay == 2'h0) ? ST_DATA : ST_DELAY;
        rcnt_reg <= {CW{1'b0}};
        rwait_reg <= 1'b0;
      end else if (rx_edge) begin
        case (rst_reg)
          ST_DELAY: begin
            if (rcnt_reg[1:0] + 2'h1 >= i_rx_data_delay) begin
              rst_reg <= ST_DATA;
              rcnt_reg <= {CW{1'b0}};
            end else begin
              rcnt_reg <= rcnt_reg + 1'b1;
            end
          end
          ST_DATA: begin
            rsr_reg <= {rsr_reg[WORD_BITS-2:0], din_s}; // [R07]
            if (rcnt_reg == LAST_BIT) begin
              rst_reg <= ST_IDLE;
              rcnt_reg <= {CW{1'b0}};
              rsr_full_reg <= 1'b1;
              if (relem_reg != `SPEH_MIN_ELEMS_OVR) begin
                relem_reg <= relem_reg + 2'h1;
              end
            end else begin
              rcnt_reg <= rcnt_reg + 1'b1;
            end
          end
          default: rst_reg <= ST_IDLE;
        endcase
      end
      // Shifter drains into a free buffer, else next element overwrites it
      if (rsr_full_reg && r_copy_ok && !r_done) begin
        rsr_full_reg <= 1'b0; // [R02]
      end
      if (rx_overrun_flag_reg && i_rx_data_rd) begin
        rst_reg <= ST_IDLE; // [R05] Read during overrun ends any frame; a new sync restarts
      end
    end
  end
  // Buffer, data register, ready and overrun
  always @(posedge i_clk) begin
    if (~rx_run) begin
      rbr_reg <= {WORD_BITS{1'b0}};
      drr_reg <= {WORD_BITS{1'b0}};
      rbr_full_reg <= 1'b0;
      rx_ready_flag_reg <= 1'b0;
      rx_overrun_flag_reg <= 1'b0;
    end else begin
      if (rsr_full_reg && r_copy_ok) begin
        rbr_reg <= rsr_reg; // [R02]
        rbr_full_reg <= 1'b1;
      end else if (rb2d) begin
        rbr_full_reg <= 1'b0;
      end
      if (rb2d) begin
        drr_reg <= rbr_reg;
        rx_ready_flag_reg <= 1'b1;
      end else if (i_rx_data_rd) begin
        rx_ready_flag_reg <= 1'b0;
      end
      // Read clears; read wins over a fresh overrun set in the same cycle
      if (i_rx_data_rd) begin
        rx_overrun_flag_reg <= 1'b0; // [R05]
      end else if (rx_ready_flag_reg && rbr_full_reg && rsr_full_reg
                   && relem_reg == `SPEH_MIN_ELEMS_OVR) begin
        rx_overrun_flag_reg <= 1'b1; // [R01] [R03]
      end
    end
  end
  // Receive sync error flag: hardware set wins over software clear
  always @(posedge i_clk) begin
    if (~rx_run) begin
      rx_sync_error_flag_reg <= 1'b0;
    end else if (r_unexp && !i_rx_sync_ignore) begin
      rx_sync_error_flag_reg <= 1'b1; // [R09]
    end else if (i_rx_sync_err_wr) begin
      rx_sync_error_flag_reg <= i_rx_sync_err_wdata; // [R09]
    end
  end

  // ---------------- Transmitter ----------------
  reg [1:0] tst_reg;
  reg [CW-1:0] tcnt_reg;
  reg [WORD_BITS-1:0] dxr_reg;
  reg [WORD_BITS-1:0] xsr_reg;
  reg [WORD_BITS-1:0] xcur_reg;
  reg dxr_new_reg;
  reg tx_ready_flag_reg;
  reg tx_empty_n_n_reg;
  reg tstarted_reg;
  reg tx_sync_error_flag_reg;
  reg dout_reg;
  reg gen_fs_reg;
  wire tx_run = ~i_reset & i_tx_reset_n;
  wire copy_mode = i_tx_sync_source_sel & ~i_tx_sync_gen_mode;
  // Copy mode makes its own sync; the pin is used otherwise
  wire t_fs = copy_mode ? gen_fs_reg : tfs_s;
  wire [CW-1:0] t_left = LAST_BIT - tcnt_reg;
  wire t_early = tstarted_reg && (tst_reg == ST_DATA)
                 && (t_left >= {{(CW-2){1'b0}}, i_tx_data_delay}); // [R18] [R20]
  wire t_sync = tx_edge & t_fs;
  wire t_unexp = t_sync & t_early;
  wire t_norm = t_sync & ~t_early;
  // Copy into shifter happens at an accepted frame start with new data pending
  wire t_copy = t_norm & dxr_new_reg;
  always @(posedge i_clk) begin
    if (~tx_run) begin
      tst_reg <= ST_IDLE;
      tcnt_reg <= {CW{1'b0}};
      xsr_reg <= {WORD_BITS{1'b0}};
      xcur_reg <= {WORD_BITS{1'b0}};
      dxr_reg <= {WORD_BITS{1'b0}};
      dxr_new_reg <= 1'b0;
      tx_ready_flag_reg <= 1'b1; // [R16]
      tx_empty_n_n_reg <= 1'b0; // [R13] [R16]
      tstarted_reg <= 1'b0;
      dout_reg <= 1'b0;
      gen_fs_reg <= 1'b0;
    end else begin
      if (tx_edge) gen_fs_reg <= 1'b0; // Held until the bit clock can see it
      if (i_tx_data_wr) begin
        dxr_reg <= i_tx_data; // [R11]
        dxr_new_reg <= 1'b1;
        tx_ready_flag_reg <= 1'b0;
        // No sync in copy mode until host supplies data
        if (copy_mode && tst_reg == ST_IDLE) begin
          gen_fs_reg <= 1'b1; // [R15]
        end
      end
      if (t_unexp && !i_tx_sync_ignore) begin // [R19]
        // Restart the same element after the delay
        xsr_reg <= xcur_reg; // [R24]
        tst_reg <= (i_tx_data_delay == 2'h0) ? ST_DATA : ST_DELAY;
        tcnt_reg <= {CW{1'b0}};
      end else if (t_norm) begin
        tstarted_reg <= 1'b1;
        tst_reg <= (i_tx_data_delay == 2'h0) ? ST_DATA : ST_DELAY;
        tcnt_reg <= {CW{1'b0}};
        if (t_copy) begin
          xsr_reg <= dxr_reg;
          xcur_reg <= dxr_reg;
          dxr_new_reg <= i_tx_data_wr;
          tx_ready_flag_reg <= ~i_tx_data_wr; // Write landing with the copy is still pending
          tx_empty_n_n_reg <= 1'b1; // [R14]
        end else begin
          // Underflow resends old data; zeros before any load
          xsr_reg <= dxr_reg; // [R14] [R16]
          xcur_reg <= dxr_reg;
        end
      end else if (tx_edge) begin
        case (tst_reg)
          ST_DELAY: begin
            if (tcnt_reg[1:0] + 2'h1 >= i_tx_data_delay) begin
              tst_reg <= ST_DATA;
              tcnt_reg <= {CW{1'b0}};
            end else begin
              tcnt_reg <= tcnt_reg + 1'b1;
            end
          end
          ST_DATA: begin
            dout_reg <= xsr_reg[WORD_BITS-1];
            xsr_reg <= {xsr_reg[WORD_BITS-2:0], 1'b0};
            if (tcnt_reg == LAST_BIT) begin
              tst_reg <= ST_IDLE;
              tcnt_reg <= {CW{1'b0}};
              if (!dxr_new_reg && !i_tx_data_wr) begin
                tx_empty_n_n_reg <= 1'b0; // [R13]
              end
            end else begin
              tcnt_reg <= tcnt_reg + 1'b1;
            end
          end
          default: dout_reg <= 1'b0;
        endcase
      end
    end
  end
  // Transmit sync error flag, cleared while transmitter disabled
  always @(posedge i_clk) begin
    if (~tx_run) begin
      tx_sync_error_flag_reg <= 1'b0; // [R17]
    end else if (t_unexp && !i_tx_sync_ignore) begin
      tx_sync_error_flag_reg <= 1'b1; // [R21]
    end else if (i_tx_sync_err_wr) begin
      tx_sync_error_flag_reg <= i_tx_sync_err_wdata; // [R21]
    end
  end

  assign o_rx_data = drr_reg;
  assign o_serial_out = dout_reg;
  assign o_tx_frame_sync = gen_fs_reg;
  assign o_rx_ready_flag = rx_ready_flag_reg;
  assign o_rx_overrun_flag = rx_overrun_flag_reg;
  assign o_rx_sync_error_flag = rx_sync_error_flag_reg;
  assign o_tx_ready_flag = tx_ready_flag_reg;
  assign o_tx_empty_n = tx_empty_n_n_reg;
  assign o_tx_sync_error_flag = tx_sync_error_flag_reg;
  assign o_tx_dma_event = tx_ready_flag_reg & tx_run;
  // Interrupt routing by mode
  assign o_rx_irq = (i_rx_irq_mode == `SPEH_IRQM_SYNCERR) ? rx_sync_error_flag_reg
                  : (i_rx_irq_mode == `SPEH_IRQM_READY) ? rx_ready_flag_reg : 1'b0; // [R10]
  assign o_tx_irq = (i_tx_irq_mode == `SPEH_IRQM_SYNCERR) ? tx_sync_error_flag_reg
                  : (i_tx_irq_mode == `SPEH_IRQM_READY) ? tx_ready_flag_reg : 1'b0; // [R12] [R22]
endmodule // speh_serial_port

/* speh_map.vh */
`ifndef SPEH_MAP_VH
`define SPEH_MAP_VH
// Interrupt mode encodings
`define SPEH_IRQM_READY 2'h0
`define SPEH_IRQM_SYNCERR 2'h3
// Element geometry defaults
`define SPEH_WORD_BITS 8
`define SPEH_CNT_W 6
// Overrun may only appear once this many elements have arrived
`define SPEH_MIN_ELEMS_OVR 2'h3
// Reset values
`define SPEH_ZERO_WORD 32'h0000_0000
`endif

/* speh_sync2.v */
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs, width parameterised
module speh_sync2 #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_reset,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  // First stage read only by the second
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule // speh_sync2

/* speh_serial_port_assertions.sv */
`timescale 1ns/10ps
// Ties status flags and irq lines to their causes at the ports
module speh_serial_port_assertions (
  input wire i_clk,
  input wire i_reset,
  input wire i_rx_reset_n,
  input wire i_tx_reset_n,
  input wire [1:0] i_rx_irq_mode,
  input wire [1:0] i_tx_irq_mode,
  input wire i_rx_data_rd,
  input wire i_rx_sync_err_wr,
  input wire i_rx_sync_err_wdata,
  input wire i_tx_sync_err_wr,
  input wire i_tx_sync_err_wdata,
  input wire o_rx_ready_flag,
  input wire o_rx_overrun_flag,
  input wire o_rx_sync_error_flag,
  input wire o_tx_ready_flag,
  input wire o_tx_empty_n,
  input wire o_tx_sync_error_flag,
  input wire o_rx_irq,
  input wire o_tx_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Irq routing is combinational, so it must agree every cycle
  rx_irq_err_a: assert property (i_rx_irq_mode == 2'h3 |->
    o_rx_irq == o_rx_sync_error_flag)
    else $error("rx irq does not follow sync error");
  tx_irq_err_a: assert property (i_tx_irq_mode == 2'h3 |->
    o_tx_irq == o_tx_sync_error_flag)
    else $error("tx irq does not follow sync error");
  tx_irq_ready_a: assert property (i_tx_irq_mode == 2'h0 |-> o_tx_irq == o_tx_ready_flag)
    else $error("tx irq does not follow ready");
  // Overrun only while unread data still sits in the data register
  ovr_needs_ready_a: assert property ($rose(o_rx_overrun_flag) |-> $past(o_rx_ready_flag))
    else $error("overrun set with data register already read");
  ovr_read_clr_a: assert property (i_rx_data_rd |=> !o_rx_overrun_flag)
    else $error("overrun survived a data read");
  rx_rst_clr_a: assert property (!i_rx_reset_n |=>
    !o_rx_overrun_flag && !o_rx_sync_error_flag)
    else $error("receiver reset left a flag set");
  rx_err_wr_a: assert property (i_rx_sync_err_wr && !i_rx_sync_err_wdata |=>
    !o_rx_sync_error_flag)
    else $error("rx sync error not cleared by write");
  tx_err_set_a: assert property (i_tx_sync_err_wr && i_tx_sync_err_wdata && i_tx_reset_n
    |=> o_tx_sync_error_flag)
    else $error("tx sync error not set by write");
  tx_rst_state_a: assert property (!i_tx_reset_n |=> o_tx_ready_flag && !o_tx_empty_n
    && !o_tx_sync_error_flag)
    else $error("transmitter reset state wrong");
  // A fresh copy ends underflow; the written data had dropped ready
  empty_copy_a: assert property ($rose(o_tx_empty_n) |-> !$past(o_tx_ready_flag, 2))
    else $error("empty cleared without new data");
  cover property ($rose(o_rx_overrun_flag));
  cover property ($rose(o_rx_sync_error_flag));
  cover property ($rose(o_tx_sync_error_flag));
endmodule // speh_serial_port_assertions

/* speh_serial_port_partner.sv */
`timescale 1ns/10ps
// Far serial device; bit clocks run only within frames
module speh_serial_port_partner (
  output reg o_rx_bit_clock,
  output reg o_rx_frame_sync,
  output reg o_serial_in,
  output reg o_tx_bit_clock,
  output reg o_tx_frame_sync,
  input wire i_serial_out
);
  initial begin
    {o_rx_bit_clock, o_rx_frame_sync, o_serial_in} = 3'h0;
    {o_tx_bit_clock, o_tx_frame_sync} = 2'h0;
  end
  // Sync, one delay edge, then n bits MSB first, changed on rise
  task rx_frame(input [7:0] v, input integer n);
    integer i;
    begin
      for (i = 0; i <= n + 1; i = i + 1) begin
        #160 o_rx_bit_clock = 1'b1;
        o_rx_frame_sync = (i == 0);
        if (i > 1) o_serial_in = v[9 - i];
        #160 o_rx_bit_clock = 1'b0;
      end
      #160 o_rx_frame_sync = 1'b0;
      // Released line shows the inverse, never a stale valid bit
      o_serial_in = ~o_serial_in;
    end
  endtask
  // Sync on rise, delay edge, then bits; each caught late in the next cycle
  task tx_frame(input integer n, output [7:0] got);
    integer i;
    begin
      got = 8'h00;
      for (i = 0; i <= n + 2; i = i + 1) begin
        o_tx_frame_sync = (i == 0);
        #160;
        if (i >= 3) got = {got[6:0], i_serial_out};
        o_tx_bit_clock = 1'b1;
        #160 o_tx_bit_clock = 1'b0;
      end
    end
  endtask
endmodule // speh_serial_port_partner

/* serial_port_error_handling_test.sv */
`timescale 1ns/10ps
// Self-checking bench for serial port error handling
module serial_port_error_handling_test;
  reg i_clk = 1'b0;
  reg i_reset = 1'b1;
  reg rx_rst_n, tx_rst_n, rx_ign, tx_ign, rd, wr, rew, rewd, tew, tewd;
  reg [1:0] rx_irqm, tx_irqm;
  reg tsel = 1'b0;
  wire fso, dma;
  reg [7:0] wdata, got;
  wire rxc, rxs, sin, txc, txs, sout, rx_rdy, ovr, rx_err, tx_rdy, empty_n, tx_err, rx_irq, tx_irq;
  wire [7:0] rdata;
  integer miscompares = 0;
  integer checks = 0;
  always #20 i_clk = ~i_clk;
  // Delay fixed at one bit; sync generator mode bit held at zero
  speh_serial_port #(.WORD_BITS(8)) DUT (.i_clk(i_clk), .i_reset(i_reset),
    .i_rx_bit_clock(rxc), .i_rx_frame_sync(rxs), .i_serial_in(sin), .i_tx_bit_clock(txc),
    .i_tx_frame_sync(txs), .o_serial_out(sout), .o_tx_frame_sync(fso), .i_rx_reset_n(rx_rst_n),
    .i_tx_reset_n(tx_rst_n), .i_rx_sync_ignore(rx_ign), .i_tx_sync_ignore(tx_ign),
    .i_rx_data_delay(2'h1), .i_tx_data_delay(2'h1), .i_rx_irq_mode(rx_irqm),
    .i_tx_irq_mode(tx_irqm), .i_tx_sync_source_sel(tsel), .i_tx_sync_gen_mode(1'b0),
    .i_rx_data_rd(rd), .o_rx_data(rdata), .i_tx_data_wr(wr), .i_tx_data(wdata),
    .i_rx_sync_err_wr(rew), .i_rx_sync_err_wdata(rewd), .i_tx_sync_err_wr(tew),
    .i_tx_sync_err_wdata(tewd), .o_rx_ready_flag(rx_rdy), .o_rx_overrun_flag(ovr),
    .o_rx_sync_error_flag(rx_err), .o_tx_ready_flag(tx_rdy), .o_tx_empty_n(empty_n),
    .o_tx_sync_error_flag(tx_err), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq), .o_tx_dma_event(dma));
  speh_serial_port_partner p (.o_rx_bit_clock(rxc), .o_rx_frame_sync(rxs), .o_serial_in(sin),
    .o_tx_bit_clock(txc), .o_tx_frame_sync(txs), .i_serial_out(sout));
  task chk(input [31:0] v, input [31:0] e);
    begin
      checks = checks + 1;
      if (v !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: got %0h expected %0h", $time, v, e);
      end
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task step(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task host_wr(input [7:0] v);
    begin
      wdata = v;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
    end
  endtask
  task t_overrun;
    begin
      p.rx_frame(8'hA1, 8);
      p.rx_frame(8'hB2, 8);
      step(12);
      chk(ovr, 1'b0);
      chk(rdata, 8'hA1);
      p.rx_frame(8'hC3, 8);
      step(12);
      chk(ovr, 1'b1);
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(12);
      chk(ovr, 1'b0);
      chk(rdata, 8'hB2);
    end
  endtask
  // Early sync after four bits, first ignored, then honoured
  task t_rx_sync;
    begin
      rx_ign = 1'b1;
      p.rx_frame(8'h5A, 4);
      p.rx_frame(8'h5A, 8);
      step(12);
      chk(rx_err, 1'b0);
      rx_rst_n = 1'b0;
      step(2);
      chk(rx_rdy, 1'b0);
      {rx_rst_n, rx_ign, rx_irqm} = 4'hB;
      p.rx_frame(8'h5A, 4);
      p.rx_frame(8'h69, 8);
      step(12);
      chk(rx_err, 1'b1);
      chk(rx_irq, 1'b1);
      chk(rdata, 8'h69);
      {rew, rewd} = 2'h2;
      step(1);
      rew = 1'b0;
      step(1);
      chk(rx_err, 1'b0);
    end
  endtask
  task t_tx;
    begin
      chk({tx_rdy, empty_n, dma}, 3'h5);
      p.tx_frame(8, got);
      chk(got, 8'h00);
      host_wr(8'hA5);
      host_wr(8'h3C);
      chk(tx_irq, 1'b0);
      chk(dma, 1'b0);
      fork
        p.tx_frame(8, got);
        begin
          step(40);
          chk(empty_n, 1'b1);
          chk(tx_irq, 1'b1);
        end
      join
      chk(got, 8'h3C);
      step(12);
      chk(empty_n, 1'b0);
      p.tx_frame(8, got);
      chk(got, 8'h3C);
    end
  endtask
  task t_tx_sync;
    begin
      tx_irqm = 2'h3;
      host_wr(8'h96);
      p.tx_frame(4, got);
      p.tx_frame(8, got);
      chk(got, 8'h96);
      step(12);
      chk(tx_err, 1'b1);
      chk(tx_irq, 1'b1);
      {tew, tewd} = 2'h2;
      step(1);
      {tew, tewd} = 2'h1;
      step(1);
      chk(tx_err, 1'b0);
      tew = 1'b1;
      step(1);
      tew = 1'b0;
      step(1);
      chk(tx_err, 1'b1);
      tx_rst_n = 1'b0;
      step(2);
      {tx_rst_n, tx_ign} = 2'h3;
      chk(tx_err, 1'b0);
      p.tx_frame(4, got);
      p.tx_frame(8, got);
      step(12);
      chk(tx_err, 1'b0);
    end
  endtask
  // Early read during the third element averts the overrun
  task t_ovr_avert;
    begin
      rx_rst_n = 1'b0;
      step(2);
      rx_rst_n = 1'b1;
      p.rx_frame(8'h1E, 8);
      p.rx_frame(8'h2D, 8);
      fork
        p.rx_frame(8'h3C, 8);
        begin
          step(8);
          rd = 1'b1;
          step(1);
          rd = 1'b0;
        end
      join
      step(12);
      chk(ovr, 1'b0);
      chk(rdata, 8'h2D);
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(4);
      chk(rdata, 8'h3C);
    end
  endtask
  // Copy-driven sync: a write makes one frame, none follows without data
  task t_copy_sync;
    begin
      tsel = 1'b1;
      host_wr(8'h5C);
      chk(fso, 1'b1);
      p.tx_frame(8, got);
      chk(got, 8'h5C);
      chk(fso, 1'b0);
      p.tx_frame(8, got);
      chk(got, 8'h00);
      tsel = 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Main sequence after eight cycles of reset
  initial begin
    {rx_rst_n, tx_rst_n, rx_ign, tx_ign, rd, wr, rew, rewd, tew, tewd} = 10'h300;
    {rx_irqm, tx_irqm, wdata} = 12'h000;
    step(8);
    i_reset = 1'b0;
    step(2);
    t_overrun;
    t_rx_sync;
    t_ovr_avert;
    t_tx;
    t_tx_sync;
    t_copy_sync;
    summarize;
  end
  // Watchdog well past the roughly 66 us of traffic
  initial begin
    #400000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule // serial_port_error_handling_test
bind speh_serial_port speh_serial_port_assertions chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_rx_reset_n(i_rx_reset_n), .i_tx_reset_n(i_tx_reset_n), .i_rx_irq_mode(i_rx_irq_mode),
  .i_tx_irq_mode(i_tx_irq_mode), .i_rx_data_rd(i_rx_data_rd), .i_rx_sync_err_wr(i_rx_sync_err_wr),
  .i_rx_sync_err_wdata(i_rx_sync_err_wdata), .i_tx_sync_err_wr(i_tx_sync_err_wr),
  .i_tx_sync_err_wdata(i_tx_sync_err_wdata), .o_rx_ready_flag(o_rx_ready_flag),
  .o_rx_overrun_flag(o_rx_overrun_flag), .o_rx_sync_error_flag(o_rx_sync_error_flag),
  .o_tx_ready_flag(o_tx_ready_flag), .o_tx_empty_n(o_tx_empty_n),
  .o_tx_sync_error_flag(o_tx_sync_error_flag), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq));
